// File: src/scb_pkg.sv
package scb_pkg;
  // Register map
  localparam int             NREG = 35;               // Control registers in the map
  localparam int             IW   = 6;                // Width of a register index
  localparam logic [IW-1:0]  IDX_END   = 6'h23;       // Index past the last register
  localparam logic [IW-1:0]  IDX_MODE  = 6'h00;       // Mode and supply control
  localparam logic [IW-1:0]  IDX_HW0   = 6'h01;       // Hardware control 0
  localparam logic [IW-1:0]  IDX_HW1   = 6'h09;       // Hardware control 1
  localparam logic [IW-1:0]  IDX_HW2   = 6'h0A;       // Hardware control 2
  localparam logic [IW-1:0]  IDX_GPIO  = 6'h0B;       // GPIO configuration
  localparam logic [6:0] REG_ADDR [NREG] = '{         // Ascending register addresses
    7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07, 7'h08, 7'h0B, 7'h0C, 7'h0E, 7'h0F, 7'h17,
    7'h18, 7'h1C, 7'h1D, 7'h1E, 7'h1F, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26,
    7'h27, 7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h30, 7'h31};
  // Values and fields
  localparam logic [7:0] POR_VAL     = 8'h00;         // Power-on and soft reset value
  localparam logic [7:0] RESTART_VAL = 8'h00;         // Restart value of non-kept bits
  localparam logic [7:0] MODE_FIELD  = 8'hC0;         // Mode field of mode control
  localparam logic [7:0] MODE_SOFT   = 8'hC0;         // Mode code that orders soft reset
  localparam logic [7:0] PRI_LOCK    = 8'h20;         // Primary lock bit in hw control 1
  localparam logic [7:0] PERM_LOCK   = 8'h20;         // Permanent lock bit in hw control 2
  localparam logic [7:0] ALL_BITS    = 8'hFF;         // Whole byte
  localparam logic [7:0] NO_BITS     = 8'h00;         // Empty mask
  // Bits that the link may write
  function automatic logic [7:0] wrMask(input int i);
    if (i == int'(IDX_MODE)) return 8'hDF;
    else if (i == int'(IDX_HW0)) return 8'h65;
    else return ALL_BITS;
  endfunction
  // Bits that the chip itself may update
  function automatic logic [7:0] hwMask(input int i);
    if (i == int'(IDX_MODE)) return 8'hDC;
    else if (i == int'(IDX_HW0)) return 8'h20;
    else return NO_BITS;
  endfunction
  // Bits held by the primary lock
  function automatic logic [7:0] priMask(input int i);
    if (i == int'(IDX_HW0)) return 8'h04;
    else if (i == int'(IDX_GPIO)) return ALL_BITS;
    else return NO_BITS;
  endfunction
  // Bits held by the permanent lock
  function automatic logic [7:0] permMask(input int i);
    if (i == int'(IDX_HW0)) return 8'h44;
    else if (i == int'(IDX_GPIO)) return ALL_BITS;
    else if (i == int'(IDX_HW2)) return PERM_LOCK;
    else return NO_BITS;
  endfunction
  // Bits that keep their content on restart
  function automatic logic [7:0] keepMask(input int i);
    if (i == int'(IDX_MODE)) return 8'h03;
    else if (i == int'(IDX_HW0)) return 8'h45;
    else return ALL_BITS;
  endfunction
  // Host register offsets and timing
  localparam logic [3:0] OFS_CMD  = 4'h0;             // Command word
  localparam logic [3:0] OFS_STAT = 4'h4;             // Busy status
  localparam logic [3:0] OFS_RX   = 4'h8;             // Bytes returned by the last frame
  localparam int         CMD_LONG_BIT   = 24;         // Selects a 24-bit frame
  localparam int         CLK_PERIOD_NS  = 4;          // System clock period
  localparam int         SCLK_HALF_NS   = 80;         // Half period of the link clock
  localparam int         SCLK_HALF_CYC  = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [4:0] LAST_BIT_SHORT = 5'h0F;      // Last bit of a 16-bit frame
  localparam logic [4:0] LAST_BIT_LONG  = 5'h17;      // Last bit of a 24-bit frame
  localparam logic [1:0] RESP_OK  = 2'h0;             // Bus answer, accepted
  localparam logic [1:0] RESP_ERR = 2'h2;             // Bus answer, unmapped
  // Host frame sequencer states
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_LOW  = 4'h2,
    HS_HIGH = 4'h4,
    HS_GAP  = 4'h8
  } scb_host_st_e;
endpackage

// File: src/scb_spi_if.sv
interface scb_spi_if;
  logic sclk;     // Link clock from the host
  logic csN;      // Frame select, active low
  logic mosi;     // Host to device data
  logic misoOut;  // Device data out
  logic misoOe;   // Device drives the return line
  logic miso;     // Resolved return line
  // Undriven line reads low
  assign miso = misoOe & misoOut;
  modport device (input sclk, input csN, input mosi, output misoOut, output misoOe);
  modport host (output sclk, output csN, output mosi, input miso);
endinterface

// File: src/scb_device_end.sv
// Overview of operation
// RL1 - Power-on or soft reset loads reset values
// RL2 - Restart loads restart value, keeps marked bits
// RL3 - Frame: address, mode bit, then data byte
// RL4 - Data bits D0..D7 travel as bits 8..15
// RL5 - Extra byte reaches the next valid address
// RL6 - Read-only and reserved bits ignore writes
// RL7 - Plain bits change only by link writes
// RL8 - Hardware bits also updated by chip logic
// RL9 - Either lock bit freezes lockable bits
// RL10 - Primary lock survives soft reset, software clears
// RL11 - Permanent lock holds until power-on reset
// RL12 - Soft reset spares locked configurations only; code also spares the primary lock bit
// RL13 - Reserved bits read zero, written zero
// RL14 - Mode bit low reads without writing
// RL15 - Mode bit high writes the data byte
// RL16 - Chip never alters plain control bits
// RL17 - Write returns previous register content
// RL18 - Unmapped or read-only writes change nothing
module scb_device_end (
  input  wire logic                         clk,
  input  wire logic                         rst,
  scb_spi_if.device                         spi,
  input  wire logic                         restartReq,
  input  wire logic                         hwWrValid,
  input  wire logic [scb_pkg::IW-1:0]       hwWrIdx,
  input  wire logic [7:0]                   hwWrData,
  output logic      [scb_pkg::NREG*8-1:0]   ctrlRegs,
  output logic                              softResetPulse
);
  // Link domain, frame position
  logic             linkRst;     // Power-on reset or frame end
  logic [2:0]       bitQ;        // Bit within the current byte
  logic [2:0]       bitD;
  logic             firstQ;      // Still in the command byte
  logic             firstD;
  // Link domain, captured command
  logic [7:0]       rxQ;         // Incoming shift, LSB first
  logic [7:0]       rxD;
  logic [6:0]       addrHoldQ;   // Address held for the system side
  logic [6:0]       addrHoldD;
  logic             modeHoldQ;   // Access mode held for the system side
  logic             modeHoldD;
  logic [7:0]       dataHoldQ;   // Data byte held for the system side
  logic [7:0]       dataHoldD;
  logic             addrTglQ;    // Toggles when an address is complete
  logic             addrTglD;
  logic             dataTglQ;    // Toggles when a data byte is complete
  logic             dataTglD;
  // Link domain, return data
  logic [7:0]       txQ;         // Outgoing shift
  logic [7:0]       txD;
  logic             misoQ;
  logic             misoD;
  logic             oeQ;
  // System domain
  logic [2:0]       addrSyncQ;   // Synchroniser plus edge stage
  logic [2:0]       dataSyncQ;
  logic             addrEv;      // New address arrived
  logic             dataEv;      // New data byte arrived
  logic [scb_pkg::IW-1:0] curIdxQ; // Register under access
  logic [scb_pkg::IW-1:0] curIdxD;
  logic             curHitQ;     // Access hits a mapped register
  logic             curHitD;
  logic [7:0]       rdDataQ;     // Byte to return, stable while shifted
  logic [7:0]       rdDataD;
  logic [7:0]       regQ [scb_pkg::NREG];
  logic [7:0]       regD [scb_pkg::NREG];
  logic             softPendQ;   // Soft reset ordered by last write
  logic             softPendD;
  logic             softDoneQ;
  logic             wrEv;
  logic             priOn;
  logic             permOn;
  logic [7:0]       lockM;
  logic [7:0]       effM;
  logic [7:0]       spareM;
  logic [scb_pkg::IW-1:0] nIdx;

  // First mapped entry at or above an address, with hit flag
  function automatic logic [scb_pkg::IW:0] findIdx(input logic [6:0] a);
    logic [scb_pkg::IW-1:0] idx;
    logic                   hit;
    idx = scb_pkg::IDX_END;
    hit = 1'b0;
    for (int i = scb_pkg::NREG - 1; i >= 0; i--) begin
      if (scb_pkg::REG_ADDR[i] >= a) begin
        idx = scb_pkg::IW'(i);
        hit = (scb_pkg::REG_ADDR[i] == a);
      end
    end
    return {hit, idx};
  endfunction

  assign linkRst = rst | spi.csN;

  // Bit position; a raised select abandons any partial byte
  always_comb begin
    bitD   = bitQ + 3'h1;
    firstD = firstQ & (bitQ != 3'h7); // [RL3]
  end

  always_ff @(posedge spi.sclk or posedge linkRst) begin
    if (linkRst) begin
      bitQ   <= 3'h0;
      firstQ <= 1'b1;
    end else begin
      bitQ   <= bitD;
      firstQ <= firstD;
    end
  end

  // Capture address, mode and data; hand address and data over by a toggle
  always_comb begin
    rxD       = {spi.mosi, rxQ[7:1]}; // [RL4]
    addrHoldD = addrHoldQ;
    modeHoldD = modeHoldQ;
    dataHoldD = dataHoldQ;
    addrTglD  = addrTglQ;
    dataTglD  = dataTglQ;
    if (firstQ && bitQ == 3'h6) begin
      addrHoldD = rxD[7:1]; // [RL3]
      addrTglD  = ~addrTglQ;
    end else if (firstQ && bitQ == 3'h7) begin
      modeHoldD = spi.mosi; // [RL14] [RL15]
    end else if (!firstQ && bitQ == 3'h7) begin
      dataHoldD = rxD;
      dataTglD  = ~dataTglQ;
    end
  end

  always_ff @(posedge spi.sclk or posedge rst) begin
    if (rst) begin
      rxQ       <= 8'h00;
      addrHoldQ <= 7'h00;
      modeHoldQ <= 1'b0;
      dataHoldQ <= 8'h00;
      addrTglQ  <= 1'b0;
      dataTglQ  <= 1'b0;
    end else begin
      rxQ       <= rxD;
      addrHoldQ <= addrHoldD;
      modeHoldQ <= modeHoldD;
      dataHoldQ <= dataHoldD;
      addrTglQ  <= addrTglD;
      dataTglQ  <= dataTglD;
    end
  end

  // Return data on falling edges; the command byte answers zero
  always_comb begin
    txD   = {1'b0, txQ[7:1]};
    misoD = txQ[0];
    if (firstQ) begin
      txD   = 8'h00;
      misoD = 1'b0;
    end else if (bitQ == 3'h0) begin
      // Read byte settled three system clocks after a rising link edge, before this falling edge
      txD   = {1'b0, rdDataQ[7:1]}; // [RL4] [RL17]
      misoD = rdDataQ[0];
    end
  end

  always_ff @(negedge spi.sclk or posedge linkRst) begin
    if (linkRst) begin
      txQ   <= 8'h00;
      misoQ <= 1'b0;
      oeQ   <= 1'b0;
    end else begin
      txQ   <= txD;
      misoQ <= misoD;
      oeQ   <= 1'b1;
    end
  end

  assign spi.misoOut = misoQ;
  assign spi.misoOe  = oeQ;

  // Events from the link domain
  assign addrEv = addrSyncQ[1] ^ addrSyncQ[2];
  assign dataEv = dataSyncQ[1] ^ dataSyncQ[2];
  assign wrEv   = dataEv & modeHoldQ & curHitQ; // [RL15] [RL14] [RL18]
  assign priOn  = |(regQ[scb_pkg::IDX_HW1] & scb_pkg::PRI_LOCK);
  assign permOn = |(regQ[scb_pkg::IDX_HW2] & scb_pkg::PERM_LOCK);

  // Access pointer and read byte
  always_comb begin
    curIdxD = curIdxQ;
    curHitD = curHitQ;
    rdDataD = rdDataQ;
    nIdx    = curHitQ ? curIdxQ + 6'h01 : curIdxQ; // [RL5]
    if (addrEv) begin
      {curHitD, curIdxD} = findIdx(addrHoldQ);
      rdDataD = curHitD ? regQ[curIdxD] : 8'h00; // [RL13] [RL17]
    end else if (dataEv) begin
      curIdxD = nIdx;
      curHitD = (nIdx != scb_pkg::IDX_END); // [RL5]
      rdDataD = curHitD ? regQ[nIdx] : 8'h00;
    end
  end

  // Register contents: soft reset, restart, link write, chip update
  always_comb begin
    lockM     = 8'h00;
    effM      = 8'h00;
    spareM    = 8'h00;
    softPendD = 1'b0;
    for (int i = 0; i < scb_pkg::NREG; i++) begin
      regD[i] = regQ[i];
      lockM = (priOn ? scb_pkg::priMask(i) : 8'h00) // [RL9] [RL10]
            | (permOn ? scb_pkg::permMask(i) : 8'h00); // [RL11]
      if (softPendQ) begin
        // Lock bits themselves are never undone by a soft reset
        spareM = lockM | ((i == int'(scb_pkg::IDX_HW1)) ? scb_pkg::PRI_LOCK : 8'h00);
        regD[i] = (regQ[i] & spareM) | (scb_pkg::POR_VAL & ~spareM); // [RL12] [RL1]
      end
      if (restartReq) begin
        regD[i] = (regD[i] & scb_pkg::keepMask(i))
                | (scb_pkg::RESTART_VAL & ~scb_pkg::keepMask(i)); // [RL2]
      end
      if (wrEv && curIdxQ == scb_pkg::IW'(i)) begin
        effM    = scb_pkg::wrMask(i) & ~lockM; // [RL6] [RL7] [RL9] [RL13]
        regD[i] = (regD[i] & ~effM) | (dataHoldQ & effM);
      end
      if (hwWrValid && hwWrIdx == scb_pkg::IW'(i)) begin
        // Only hardware-type bits follow the chip logic
        regD[i] = (regD[i] & ~scb_pkg::hwMask(i))
                | (hwWrData & scb_pkg::hwMask(i)); // [RL8] [RL16]
      end
    end
    if (wrEv && curIdxQ == scb_pkg::IDX_MODE
        && (dataHoldQ & scb_pkg::MODE_FIELD) == scb_pkg::MODE_SOFT) begin
      softPendD = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrSyncQ <= 3'h0;
      dataSyncQ <= 3'h0;
      curIdxQ   <= scb_pkg::IDX_END;
      curHitQ   <= 1'b0;
      rdDataQ   <= 8'h00;
      softPendQ <= 1'b0;
      softDoneQ <= 1'b0;
      for (int i = 0; i < scb_pkg::NREG; i++) begin
        regQ[i] <= scb_pkg::POR_VAL; // [RL1] [RL11]
      end
    end else begin
      addrSyncQ <= {addrSyncQ[1:0], addrTglQ};
      dataSyncQ <= {dataSyncQ[1:0], dataTglQ};
      curIdxQ   <= curIdxD;
      curHitQ   <= curHitD;
      rdDataQ   <= rdDataD;
      softPendQ <= softPendD;
      softDoneQ <= softPendQ;
      regQ      <= regD;
    end
  end

  // Flat view of every register for the chip logic
  for (genvar g = 0; g < scb_pkg::NREG; g++) begin : gFlat
    assign ctrlRegs[g*8 +: 8] = regQ[g];
  end

  assign softResetPulse = softDoneQ;
endmodule

// File: src/scb_host_end.sv
module scb_host_end (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  scb_spi_if.host          spi
);
  // Bus slave state
  logic        awHeldQ, awHeldD;   // Write address taken
  logic        wHeldQ, wHeldD;     // Write data taken
  logic [3:0]  awAddrQ, awAddrD;
  logic [31:0] wDataQ, wDataD;
  logic [3:0]  wStrbQ, wStrbD;
  logic        bvalidQ, bvalidD;
  logic [1:0]  brespQ, brespD;
  logic        rvalidQ, rvalidD;
  logic [1:0]  rrespQ, rrespD;
  logic [31:0] rdataQ, rdataD;
  logic [24:0] cmdQ, cmdD;         // Command word
  logic        startW;             // Launch a frame
  logic        busy;
  // Frame sequencer state
  scb_pkg::scb_host_st_e stQ, stD;
  logic [4:0]  divQ, divD;         // Half period divider
  logic [4:0]  bitQ, bitD;         // Bit under transfer
  logic        sclkQ, sclkD;
  logic        csNQ, csND;
  logic        mosiQ, mosiD;
  logic [23:0] rxQ, rxD;           // Returned bits
  logic [1:0]  misoSyncQ;          // Return line synchroniser
  logic [4:0]  lastBit;

  assign busy    = (stQ != scb_pkg::HS_IDLE);
  assign lastBit = cmdQ[scb_pkg::CMD_LONG_BIT] ? scb_pkg::LAST_BIT_LONG
                                               : scb_pkg::LAST_BIT_SHORT;

  // Bus slave: takes address and data in any order, answers after both
  always_comb begin
    awHeldD = awHeldQ;
    wHeldD  = wHeldQ;
    awAddrD = awAddrQ;
    wDataD  = wDataQ;
    wStrbD  = wStrbQ;
    bvalidD = bvalidQ & ~bready;
    brespD  = brespQ;
    rvalidD = rvalidQ & ~rready;
    rrespD  = rrespQ;
    rdataD  = rdataQ;
    cmdD    = cmdQ;
    startW  = 1'b0;
    if (awvalid && !awHeldQ && !bvalidQ) begin
      awHeldD = 1'b1;
      awAddrD = awaddr;
    end
    if (wvalid && !wHeldQ && !bvalidQ) begin
      wHeldD = 1'b1;
      wDataD = wdata;
      wStrbD = wstrb;
    end
    if (awHeldQ && wHeldQ) begin
      awHeldD = 1'b0;
      wHeldD  = 1'b0;
      bvalidD = 1'b1;
      brespD  = scb_pkg::RESP_OK;
      if (awAddrQ == scb_pkg::OFS_CMD) begin
        // A command written while a frame runs is dropped
        if (!busy) begin
          for (int b = 0; b < 3; b++) begin
            if (wStrbQ[b]) begin
              cmdD[b*8 +: 8] = wDataQ[b*8 +: 8];
            end
          end
          // Only the frame length bit lives in the top byte
          if (wStrbQ[3]) begin
            cmdD[scb_pkg::CMD_LONG_BIT] = wDataQ[scb_pkg::CMD_LONG_BIT];
          end
          startW = 1'b1;
        end
      end else if (awAddrQ != scb_pkg::OFS_STAT && awAddrQ != scb_pkg::OFS_RX) begin
        brespD = scb_pkg::RESP_ERR;
      end
    end
    if (arvalid && !rvalidQ) begin
      rvalidD = 1'b1;
      rrespD  = scb_pkg::RESP_OK;
      if (araddr == scb_pkg::OFS_CMD) begin
        rdataD = {7'h00, cmdQ};
      end else if (araddr == scb_pkg::OFS_STAT) begin
        rdataD = {31'h0, busy};
      end else if (araddr == scb_pkg::OFS_RX) begin
        rdataD = {8'h00, rxQ};
      end else begin
        rdataD = 32'h0;
        rrespD = scb_pkg::RESP_ERR;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeldQ <= 1'b0;
      wHeldQ  <= 1'b0;
      awAddrQ <= 4'h0;
      wDataQ  <= 32'h0;
      wStrbQ  <= 4'h0;
      bvalidQ <= 1'b0;
      brespQ  <= 2'h0;
      rvalidQ <= 1'b0;
      rrespQ  <= 2'h0;
      rdataQ  <= 32'h0;
      cmdQ    <= 25'h0;
    end else begin
      awHeldQ <= awHeldD;
      wHeldQ  <= wHeldD;
      awAddrQ <= awAddrD;
      wDataQ  <= wDataD;
      wStrbQ  <= wStrbD;
      bvalidQ <= bvalidD;
      brespQ  <= brespD;
      rvalidQ <= rvalidD;
      rrespQ  <= rrespD;
      rdataQ  <= rdataD;
      cmdQ    <= cmdD;
    end
  end

  assign awready = ~awHeldQ & ~bvalidQ;
  assign wready  = ~wHeldQ & ~bvalidQ;
  assign bvalid  = bvalidQ;
  assign bresp   = brespQ;
  assign arready = ~rvalidQ;
  assign rvalid  = rvalidQ;
  assign rresp   = rrespQ;
  assign rdata   = rdataQ;

  // Frame sequencer: data out on falling edge, sampled at rising edge
  always_comb begin
    stD   = stQ;
    divD  = (divQ == 5'h0) ? 5'(scb_pkg::SCLK_HALF_CYC - 1) : divQ - 5'h1;
    bitD  = bitQ;
    sclkD = sclkQ;
    csND  = csNQ;
    mosiD = mosiQ;
    rxD   = rxQ;
    case (stQ)
      scb_pkg::HS_IDLE: begin
        divD = 5'(scb_pkg::SCLK_HALF_CYC - 1);
        if (startW) begin
          stD   = scb_pkg::HS_LOW;
          csND  = 1'b0;
          bitD  = 5'h0;
          mosiD = cmdD[0];
          rxD   = 24'h0;
        end
      end
      scb_pkg::HS_LOW: begin
        if (divQ == 5'h0) begin
          stD         = scb_pkg::HS_HIGH;
          sclkD       = 1'b1;
          rxD[bitQ]   = misoSyncQ[1];
        end
      end
      scb_pkg::HS_HIGH: begin
        if (divQ == 5'h0) begin
          sclkD = 1'b0;
          if (bitQ == lastBit) begin
            stD = scb_pkg::HS_GAP;
          end else begin
            stD   = scb_pkg::HS_LOW;
            bitD  = bitQ + 5'h1;
            mosiD = cmdQ[bitD]; // [RL3] [RL4]
          end
        end
      end
      scb_pkg::HS_GAP: begin
        if (divQ == 5'h0) begin
          stD  = scb_pkg::HS_IDLE;
          csND = 1'b1;
        end
      end
      default: begin
        stD  = scb_pkg::HS_IDLE;
        csND = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stQ       <= scb_pkg::HS_IDLE;
      divQ      <= 5'h0;
      bitQ      <= 5'h0;
      sclkQ     <= 1'b0;
      csNQ      <= 1'b1;
      mosiQ     <= 1'b0;
      rxQ       <= 24'h0;
      misoSyncQ <= 2'h0;
    end else begin
      stQ       <= stD;
      divQ      <= divD;
      bitQ      <= bitD;
      sclkQ     <= sclkD;
      csNQ      <= csND;
      mosiQ     <= mosiD;
      rxQ       <= rxD;
      misoSyncQ <= {misoSyncQ[0], spi.miso};
    end
  end

  assign spi.sclk = sclkQ;
  assign spi.csN  = csNQ;
  assign spi.mosi = mosiQ;
endmodule

// File: testbench/scb_spi_monitor.sv
module scb_spi_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOe,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sclkQ;  // Link clock seen one cycle back
  logic [5:0] cntQ;   // Link clock rises in this frame
  logic [5:0] cntD;   // Next rise count
  // Count rises while the frame is selected
  always_comb begin
    cntD = csN ? 6'h00 : cntQ + {5'h00, sclk & !sclkQ};
  end
  // Register the helper state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkQ <= 1'b0;
      cntQ  <= 6'h00;
    end else begin
      sclkQ <= sclk;
      cntQ  <= cntD;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_SCLK_IDLE: assert property (csN |-> !sclk)
    else $error("link clock runs outside a frame");
  AST_MISO_REL: assert property (csN && $past(csN) |-> !misoOe)
    else $error("return line driven while deselected");
  AST_HALF_HI: assert property ($rose(sclk) |=> sclk [*8])
    else $error("link clock high phase too short");
  AST_CS_LEAD: assert property ($fell(csN) |-> !sclk [*8])
    else $error("first clock too soon after select");
  AST_MOSI_HOLD: assert property (sclk |-> $stable(mosi))
    else $error("host data moved while clock high");
  AST_MISO_HOLD: assert property (sclk && $past(sclk) && misoOe |-> $stable(misoOut))
    else $error("device data moved while clock high");
  AST_FRAME_LEN: assert property ($rose(csN) |-> cntQ == 6'h10 || cntQ == 6'h18)
    else $error("frame closed on a bad bit count");
  AST_CMD_ZERO: assert property (sclk && !sclkQ && !csN && cntQ < 6'h08 |-> !miso)
    else $error("command byte did not return zeros");
  // Main traffic kinds
  cover property ($rose(csN) && cntQ == 6'h10);
  cover property ($rose(csN) && cntQ == 6'h18);
  cover property (misoOe && miso);
endmodule

// File: testbench/spi_control_register_bank_tb.sv
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errTotal++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module spi_control_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, restartReq, hwWrValid;
  logic awready, wready, bvalid, arready, rvalid, softResetPulse;
  logic [3:0]                 awaddr, araddr, wstrb;
  logic [31:0]                wdata, rdata, rx;
  logic [1:0]                 bresp, rresp, rs;
  logic [scb_pkg::IW-1:0]     hwWrIdx;
  logic [7:0]                 hwWrData, m [scb_pkg::NREG];  // Expected register bytes
  logic [scb_pkg::NREG*8-1:0] ctrlRegs;
  int                         errTotal, checks, srCnt;
  scb_spi_if spiIf ();
  scb_host_end scb_host_end_inst (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .spi(spiIf));
  scb_device_end scb_device_end_inst (.clk, .rst, .spi(spiIf), .restartReq, .hwWrValid,
    .hwWrIdx, .hwWrData, .ctrlRegs, .softResetPulse);
  scb_spi_monitor scb_spi_monitor_inst (.clk, .rst, .sclk(spiIf.sclk), .csN(spiIf.csN),
    .mosi(spiIf.mosi), .misoOut(spiIf.misoOut), .misoOe(spiIf.misoOe), .miso(spiIf.miso));
  // System clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Count soft reset pulses
  always @(posedge clk) if (softResetPulse === 1'b1) srCnt++;
  // Report counts and end the run
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One bus write (w=1) or read (w=0), waits for the answer
  task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic tAw, tW, tAr, dn;
    int   n;
    @(posedge clk);
    awaddr <= a; araddr <= a; wdata <= d; awvalid <= w; wvalid <= w; arvalid <= !w;
    bready <= w; rready <= !w;
    for (n = 0; n < 200; n++) begin
      @(negedge clk);
      tAw = awvalid & awready; tW = wvalid & wready; tAr = arvalid & arready;
      dn = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge clk);
      if (tAw) awvalid <= 1'b0;
      if (tW) wvalid <= 1'b0;
      if (tAr) arvalid <= 1'b0;
      if (dn === 1'b1) begin
        bready <= 1'b0;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 200) begin errTotal++; printVerdict(); end
  endtask
  // One link frame through the command register, then fetch returned bytes
  task automatic fr(input logic [6:0] a, input logic w, input logic [7:0] d0, input logic lg);
    int n;
    axi(1'b1, 4'h0, {7'h00, lg, 8'h22, d0, w, a}, rx, rs);
    for (n = 0; n < 600; n++) begin
      axi(1'b0, 4'h4, 32'h0, rx, rs);
      if (rx[0] === 1'b0) break;
    end
    if (n == 600) begin errTotal++; printVerdict(); end
    axi(1'b0, 4'h8, 32'h0, rx, rs);
  endtask
  // Chip update (r=0) or restart (r=1) for one cycle
  task automatic hw(input logic r, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    restartReq <= r; hwWrValid <= !r; hwWrIdx <= i; hwWrData <= d;
    @(posedge clk);
    restartReq <= 1'b0; hwWrValid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Compare every register byte with the expected map
  task automatic chkAll;
    for (int i = 0; i < scb_pkg::NREG; i++) `CHK("ctrlRegs", m[i], ctrlRegs[i*8+:8])
  endtask
  // Main sequence
  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hF; restartReq = 1'b0;
    hwWrValid = 1'b0; hwWrIdx = 6'h00; hwWrData = 8'h00;
    errTotal = 0; checks = 0; srCnt = 0;
    foreach (m[i]) m[i] = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    chkAll();
    fr(7'h03, 1'b1, 8'hA5, 1'b0); m[2] = 8'hA5;
    `CHK("prev", 8'h00, rx[15:8])
    fr(7'h03, 1'b1, 8'h5A, 1'b0); m[2] = 8'h5A;
    `CHK("prev", 8'hA5, rx[15:8])
    fr(7'h03, 1'b0, 8'hFF, 1'b0);
    `CHK("read", 16'h5A00, rx[15:0])
    fr(7'h01, 1'b1, 8'h3F, 1'b0); m[0] = 8'h1F;
    fr(7'h01, 1'b0, 8'h00, 1'b0);
    `CHK("resv", 8'h1F, rx[15:8])
    fr(7'h04, 1'b1, 8'h11, 1'b1); m[3] = 8'h11; m[4] = 8'h22;
    fr(7'h05, 1'b1, 8'h77, 1'b0);
    chkAll();
    fr(7'h04, 1'b0, 8'h00, 1'b1);
    `CHK("long", 16'h2211, rx[23:8])
    hw(1'b0, 6'h00, 8'hFF); m[0] = 8'hDF;
    hw(1'b0, 6'h02, 8'h00);
    chkAll();
    hw(1'b1, 6'h00, 8'h00); m[0] = 8'h03; m[1] = 8'h00;
    chkAll();
    fr(7'h17, 1'b1, 8'hC3, 1'b0); m[11] = 8'hC3;
    fr(7'h0E, 1'b1, 8'h20, 1'b0); m[9] = 8'h20;
    fr(7'h17, 1'b1, 8'h3C, 1'b0);
    chkAll();
    fr(7'h01, 1'b1, 8'hC0, 1'b0);
    foreach (m[i]) if (i != 9 && i != 11) m[i] = 8'h00;
    chkAll();
    `CHK("softPulses", 1, srCnt)
    fr(7'h0E, 1'b1, 8'h00, 1'b0); m[9] = 8'h00;
    fr(7'h17, 1'b1, 8'h3C, 1'b0); m[11] = 8'h3C;
    chkAll();
    fr(7'h0F, 1'b1, 8'h20, 1'b0); m[10] = 8'h20;
    fr(7'h17, 1'b1, 8'h00, 1'b0);
    fr(7'h0F, 1'b1, 8'h00, 1'b0);
    chkAll();
    axi(1'b1, 4'hC, 32'h0, rx, rs);
    `CHK("bresp", scb_pkg::RESP_ERR, rs)
    axi(1'b0, 4'hC, 32'h0, rx, rs);
    `CHK("rresp", {scb_pkg::RESP_ERR, 32'h0}, {rs, rx})
    printVerdict();
  end
endmodule
